// [design/detect_pkg.sv]
// shared types of the freefall/motion detector
package detect_pkg;

    // how enabled axis results combine into the event condition
    typedef enum logic {
        COMBINE_AND,
        COMBINE_OR
    } combine_t;

    // debounce counter behaviour on a false sample
    typedef enum logic {
        DEBOUNCE_DECREMENT,
        DEBOUNCE_CLEAR
    } debounce_mode_t;

endpackage

// [design/freefall_motion_detector.sv]
// freefall/motion detector: threshold compare, debounce and source flags
//
// Functional notes
// - combine bit 0 = all enabled axes low (AND), 1 = any enabled high (OR).
// - axis motion is true when magnitude strictly exceeds the threshold.
// - freefall is true when every enabled axis magnitude is at or below threshold.
// - threshold is unsigned 7 bits, 0 to 127, 0.063 g per count.
// - compare spans 8 g; low-noise setting caps threshold at 4 g.
// - disabled axis is ignored and its flags always read zero.
// - event-active rises only when counter reaches limit with condition true.
// - clear mode resets the debounce counter on any false sample.
// - decrement mode steps counter down by one per false sample, floor zero.
// - non-latched decrement mode drops event only after full count decay.
// - non-latched clear mode drops event on the first false sample.
// - non-latched mode: source read has no side effect.
// - while event-active is low, axis flags follow undebounced compare.
// - latched mode holds event-active until source register is read.
// - latched read clears source bits and counter; new event recounts.
// - latched mode freezes axis flags once event-active sets, until read.
// - polarity flag is 0 for positive, 1 for negative acceleration.
// - event-active is presented to the interrupt logic outside.
// - debounce limit is 8-bit read/write, reset zero.
// - debounce counter saturates at the limit; above a lowered limit it is clamped by the next true sample.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "freefall_motion_detector_defines.svh"

module freefall_motion_detector #(
    parameter int ACCEL_W = 8
) (
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    input  wire logic               sample_valid,
    input  wire logic [ACCEL_W-1:0] accel_x,
    input  wire logic [ACCEL_W-1:0] accel_y,
    input  wire logic [ACCEL_W-1:0] accel_z,
    input  wire logic               low_noise,
    output logic                    event_active
);

    // -----------------------------------------------------------------------
    // reset release
    // -----------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    // two flops so release never lands mid-setup of downstream flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // -----------------------------------------------------------------------
    // register file
    // -----------------------------------------------------------------------
    logic [4:0] cfg_q;
    logic [4:0] cfg_d;
    logic [7:0] ths_q;
    logic [7:0] ths_d;
    logic [7:0] limit_q;
    logic [7:0] limit_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [5:0] flags_q;
    logic [5:0] flags_d;
    logic       ea_q;
    logic       ea_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    logic                     latch_mode;
    detect_pkg::combine_t     combine;
    detect_pkg::debounce_mode_t db_mode;
    logic [2:0]               axis_en;
    logic [5:0]               flag_mask;
    logic                     src_read;

    assign latch_mode = cfg_q[`CFG_LATCH_BIT - 3];
    assign combine    = detect_pkg::combine_t'(cfg_q[`CFG_COMBINE_BIT - 3]);
    assign db_mode    =
        detect_pkg::debounce_mode_t'(ths_q[`THS_CLEAR_MODE_BIT]);
    assign axis_en    = cfg_q[2:0];     // {z, y, x}
    assign flag_mask  = {{2{axis_en[2]}}, {2{axis_en[1]}}, {2{axis_en[0]}}};
    assign src_read   = reg_rd && (reg_addr == `DETECT_SOURCE_ADDR);

    // write decode; read data stands only in the cycle after the strobe
    always_comb begin
        cfg_d   = cfg_q;
        ths_d   = ths_q;
        limit_d = limit_q;
        rdata_d = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                `DETECT_CONFIG_ADDR:    cfg_d   = reg_wdata[7:3];
                `DETECT_THRESHOLD_ADDR: ths_d   = reg_wdata;
                `DEBOUNCE_LIMIT_ADDR:   limit_d = reg_wdata;
                default:                cfg_d   = cfg_q;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `DETECT_CONFIG_ADDR:    rdata_d = {cfg_q, 3'h0};
                `DETECT_SOURCE_ADDR:    rdata_d = {ea_q, 1'b0,
                                                   flags_q & flag_mask};
                `DETECT_THRESHOLD_ADDR: rdata_d = ths_q;
                `DEBOUNCE_LIMIT_ADDR:   rdata_d = limit_q;
                default:                rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q   <= `CFG_RESET;
            ths_q   <= `THS_RESET;
            limit_q <= `DEBOUNCE_LIMIT_RESET;
            rdata_q <= 8'h00;
        end else begin
            cfg_q   <= cfg_d;
            ths_q   <= ths_d;
            limit_q <= limit_d;
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata = rdata_q;

    // -----------------------------------------------------------------------
    // per-axis compare
    // -----------------------------------------------------------------------
    logic [ACCEL_W-1:0] accel [3];
    logic [ACCEL_W-1:0] mag   [3];
    logic [ACCEL_W-1:0] thr_eff;
    logic [6:0]         thr_raw;
    logic [2:0]         axis_hi;
    logic [5:0]         live_flags;
    logic               any_en;
    logic               cond;

    assign accel[0] = accel_x;
    assign accel[1] = accel_y;
    assign accel[2] = accel_z;
    assign thr_raw  = ths_q[`THS_VALUE_MSB:0];

    // 7-bit unsigned threshold in 0.063 g counts
    // low noise caps the threshold near 4 g, samples span 8 g
    always_comb begin
        if (low_noise && (thr_raw > 7'(`LOW_NOISE_MAX_COUNTS))) begin
            thr_eff = ACCEL_W'(`LOW_NOISE_MAX_COUNTS);
        end else begin
            thr_eff = ACCEL_W'(thr_raw);
        end
    end

    // magnitudes; the most negative code still yields its true size
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            mag[i] = accel[i][ACCEL_W-1] ? ACCEL_W'(~accel[i] + 1'b1)
                                         : accel[i];
            axis_hi[i] = mag[i] > thr_eff;
            live_flags[2*i+1] = axis_en[i] & axis_hi[i];
            live_flags[2*i]   = axis_en[i] & accel[i][ACCEL_W-1];
        end
    end

    // combined condition; no enabled axis disables the function
    assign any_en = |axis_en;
    always_comb begin
        case (combine)
            // OR of enabled axes above threshold
            detect_pkg::COMBINE_OR:  cond = any_en && |(axis_hi & axis_en);
            // every enabled axis at or below threshold
            detect_pkg::COMBINE_AND: cond = any_en &&
                                            &(~axis_hi | ~axis_en);
            default:                 cond = 1'b0;
        endcase
    end

    // -----------------------------------------------------------------------
    // debounce and source flags
    // -----------------------------------------------------------------------
    logic [7:0] cnt_base;
    logic       ea_base;
    logic       reached;

    always_comb begin
        cnt_d    = cnt_q;
        ea_d     = ea_q;
        flags_d  = flags_q;
        reached  = 1'b0;
        // latched read clears all source bits and the counter
        // a read in non-latched mode touches nothing
        if (latch_mode && src_read) begin
            cnt_d   = 8'h00;
            ea_d    = 1'b0;
            flags_d = 6'h00;
        end
        cnt_base = cnt_d;
        ea_base  = ea_d;
        // everything advances on the sample strobe only
        if (sample_valid) begin
            if (cond) begin
                // saturate at the limit, also after it is lowered
                cnt_d = (cnt_base >= limit_q) ? limit_q
                                              : 8'(cnt_base + 8'h01);
            end else if (db_mode == detect_pkg::DEBOUNCE_CLEAR) begin
                cnt_d = 8'h00;
            end else begin
                cnt_d = (cnt_base != 8'h00) ? 8'(cnt_base - 8'h01)
                                            : 8'h00;
            end
            reached = cond && (cnt_d == limit_q);
            if (latch_mode) begin
                // frozen once set; a set in a read cycle still wins
                if (!ea_base) begin
                    flags_d = live_flags;
                end
                if (reached) begin
                    ea_d = 1'b1;
                end
            end else begin
                flags_d = live_flags;
                if (db_mode == detect_pkg::DEBOUNCE_CLEAR) begin
                    ea_d = reached;
                end else if (reached) begin
                    ea_d = 1'b1;
                end else if (cnt_d == 8'h00) begin
                    ea_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= 8'h00;
            ea_q    <= 1'b0;
            flags_q <= 6'h00;
        end else begin
            cnt_q   <= cnt_d;
            ea_q    <= ea_d;
            flags_q <= flags_d;
        end
    end

    // level for the interrupt routing outside
    assign event_active = ea_q;

    // -----------------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence src_read_s;
        reg_rd && (reg_addr == `DETECT_SOURCE_ADDR);
    endsequence

    sequence false_sample_s;
        sample_valid && !cond;
    endsequence

    sequence quiet_read_s;
        src_read_s ##0 !sample_valid;
    endsequence

    combine_or_a: assert property (
        sample_valid && combine == detect_pkg::COMBINE_OR && !ea_q
        && !latch_mode && limit_q == 8'h00 && |(axis_hi & axis_en)
        |=> ea_q)
        else $error("motion on enabled axis did not raise event");

    motion_flag_a: assert property (
        sample_valid && !ea_q && axis_en[0] && mag[0] > thr_eff
        |=> flags_q[1])
        else $error("x event flag missing above threshold");

    freefall_and_a: assert property (
        sample_valid && combine == detect_pkg::COMBINE_AND
        && &axis_en && mag[0] <= thr_eff && mag[1] <= thr_eff
        && mag[2] <= thr_eff |-> cond)
        else $error("freefall condition missed");

    low_noise_cap_a: assert property (
        low_noise |-> thr_eff <= ACCEL_W'(`LOW_NOISE_MAX_COUNTS))
        else $error("threshold not capped in low noise");

    disabled_zero_a: assert property (
        src_read_s ##0 !axis_en[0] |=> reg_rdata[1:0] == 2'h0)
        else $error("disabled x flags read nonzero");

    clear_mode_a: assert property (
        false_sample_s ##0 db_mode == detect_pkg::DEBOUNCE_CLEAR
        |=> cnt_q == 8'h00)
        else $error("counter not cleared on false sample");

    decrement_a: assert property (
        false_sample_s ##0 db_mode == detect_pkg::DEBOUNCE_DECREMENT
        ##0 cnt_q != 8'h00 ##0 !src_read
        |=> cnt_q == 8'($past(cnt_q) - 8'h01))
        else $error("counter did not step down by one");

    decay_hold_a: assert property (
        !latch_mode && ea_q && db_mode == detect_pkg::DEBOUNCE_DECREMENT
        && cnt_q > 8'h01 && !reg_wr |=> ea_q)
        else $error("event dropped before count decayed");

    clear_drop_a: assert property (
        false_sample_s ##0 !latch_mode
        ##0 db_mode == detect_pkg::DEBOUNCE_CLEAR |=> !ea_q)
        else $error("event held after false sample");

    read_no_effect_a: assert property (
        quiet_read_s ##0 !latch_mode
        |=> $stable(cnt_q) && $stable(ea_q) && $stable(flags_q))
        else $error("non-latched read changed state");

    latch_hold_a: assert property (
        latch_mode && ea_q && !src_read && !reg_wr |=> ea_q)
        else $error("latched event dropped without read");

    read_clear_a: assert property (
        quiet_read_s ##0 latch_mode
        |=> !ea_q && cnt_q == 8'h00 && flags_q == 6'h00)
        else $error("latched read did not clear source");

    freeze_a: assert property (
        latch_mode && ea_q && !src_read && !reg_wr |=> $stable(flags_q))
        else $error("latched flags changed");

    saturate_a: assert property (
        sample_valid && cond && cnt_q >= limit_q && !src_read
        |=> cnt_q == $past(limit_q))
        else $error("counter passed the limit");

    rise_needs_sample_a: assert property (
        !ea_q && !(sample_valid && cond) |=> !ea_q)
        else $error("event rose without a true sample");

    polarity_y_a: assert property (
        sample_valid && !ea_q && axis_en[1]
        |=> flags_q[2] == $past(accel_y[ACCEL_W-1]))
        else $error("y polarity flag differs from sign");

    idle_hold_a: assert property (
        !sample_valid && !src_read |=> $stable(cnt_q) && $stable(ea_q))
        else $error("state moved without a sample strobe");

endmodule

`default_nettype wire

// [design/freefall_motion_detector_defines.svh]
// register map, field positions and limits of the freefall/motion detector
`ifndef FREEFALL_MOTION_DETECTOR_DEFINES_SVH
`define FREEFALL_MOTION_DETECTOR_DEFINES_SVH

// ---------------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------------
`define DETECT_CONFIG_ADDR      8'h15
`define DETECT_SOURCE_ADDR      8'h16
`define DETECT_THRESHOLD_ADDR   8'h17
`define DEBOUNCE_LIMIT_ADDR     8'h18

// ---------------------------------------------------------------------------
// detect_config fields (bits 2:0 read as zero)
// ---------------------------------------------------------------------------
`define CFG_LATCH_BIT           7
`define CFG_COMBINE_BIT         6
`define CFG_Z_EN_BIT            5
`define CFG_Y_EN_BIT            4
`define CFG_X_EN_BIT            3
`define CFG_RESET               5'h00

// ---------------------------------------------------------------------------
// detect_threshold fields
// ---------------------------------------------------------------------------
`define THS_CLEAR_MODE_BIT      7
`define THS_VALUE_MSB           6
`define THS_RESET               8'h00

// ---------------------------------------------------------------------------
// debounce limit, source and threshold scaling
// ---------------------------------------------------------------------------
`define DEBOUNCE_LIMIT_RESET    8'h00
`define SOURCE_EA_BIT           7
`define THS_LSB_MILLI_G         63
`define LOW_NOISE_MAX_MILLI_G   4000
`define LOW_NOISE_MAX_COUNTS    (`LOW_NOISE_MAX_MILLI_G / `THS_LSB_MILLI_G)

`endif

// [tb/testbench.sv]
// register-level bench of the freefall/motion detector
`timescale 1ns/1ps
`default_nettype none
`include "freefall_motion_detector_defines.svh"

// ---------------------------------------------------------------------------
// comparison macro
// ---------------------------------------------------------------------------
`define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
    end \
end

module testbench;

    logic       clock;
    logic       rstn;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       sample_valid;
    logic [7:0] accel_x;
    logic [7:0] accel_y;
    logic [7:0] accel_z;
    logic       low_noise;
    logic       event_active;
    int         n_fail;
    int         n_checks;

    freefall_motion_detector uut (
        .clock        (clock),
        .rstn         (rstn),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_rdata    (reg_rdata),
        .sample_valid (sample_valid),
        .accel_x      (accel_x),
        .accel_y      (accel_y),
        .accel_z      (accel_z),
        .low_noise    (low_noise),
        .event_active (event_active)
    );

    // 250 MHz clock
    always #2 clock = ~clock;

    // -----------------------------------------------------------------------
    // bus and sample tasks
    // -----------------------------------------------------------------------
    // one-cycle write strobe, dropped at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        @(negedge clock);
        `CHK(reg_rdata, exp)
    endtask

    // one sample strobe, then the event flag one cycle later
    task automatic smp(input logic [7:0] x, input logic [7:0] y,
                       input logic [7:0] z, input logic ea);
        @(posedge clock);
        accel_x      <= x;
        accel_y      <= y;
        accel_z      <= z;
        sample_valid <= 1'b1;
        @(posedge clock);
        sample_valid <= 1'b0;
        @(negedge clock);
        `CHK(event_active, ea)
    endtask

    // verdict, reached from the main sequence or the watchdog
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        test_done;
    end

    // -----------------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sample_valid = 1'b0;
        accel_x = 8'h00;
        accel_y = 8'h00;
        accel_z = 8'h00;
        low_noise = 1'b0;
        n_fail = 0;
        n_checks = 0;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        // internal reset copy needs two edges to release
        repeat (3) @(posedge clock);

        rd(`DETECT_CONFIG_ADDR, 8'h00);
        rd(`DETECT_THRESHOLD_ADDR, 8'h00);
        rd(`DEBOUNCE_LIMIT_ADDR, 8'h00);
        wr(`DETECT_SOURCE_ADDR, 8'hFF);
        rd(`DETECT_SOURCE_ADDR, 8'h00);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        wr(`DETECT_CONFIG_ADDR, 8'hFF);
        rd(`DETECT_CONFIG_ADDR, 8'hF8);
        wr(`DETECT_THRESHOLD_ADDR, 8'h85);
        rd(`DETECT_THRESHOLD_ADDR, 8'h85);
        wr(`DEBOUNCE_LIMIT_ADDR, 8'hA5);
        rd(`DEBOUNCE_LIMIT_ADDR, 8'hA5);

        // motion, live flags, clear-mode debounce of two
        wr(`DETECT_CONFIG_ADDR, 8'h58);
        wr(`DETECT_THRESHOLD_ADDR, 8'h8A);
        wr(`DEBOUNCE_LIMIT_ADDR, 8'h02);
        smp(8'h0B, 8'h00, 8'h9C, 1'b0);
        rd(`DETECT_SOURCE_ADDR, 8'h02);
        smp(8'hF5, 8'h00, 8'h9C, 1'b1);
        rd(`DETECT_SOURCE_ADDR, 8'h83);
        rd(`DETECT_SOURCE_ADDR, 8'h83);
        wr(`DETECT_CONFIG_ADDR, 8'h50);
        rd(`DETECT_SOURCE_ADDR, 8'h80);
        wr(`DETECT_CONFIG_ADDR, 8'h58);
        smp(8'h0A, 8'h00, 8'h00, 1'b0);
        rd(`DETECT_SOURCE_ADDR, 8'h00);
        wr(`DEBOUNCE_LIMIT_ADDR, 8'h00);
        smp(8'h0B, 8'h00, 8'h00, 1'b1);
        smp(8'h00, 8'h00, 8'h00, 1'b0);

        // decrement mode: saturation, slow decay, floor at zero
        wr(`DETECT_THRESHOLD_ADDR, 8'h0A);
        wr(`DEBOUNCE_LIMIT_ADDR, 8'h02);
        smp(8'h0B, 8'h00, 8'h00, 1'b0);
        smp(8'h0B, 8'h00, 8'h00, 1'b1);
        smp(8'h0B, 8'h00, 8'h00, 1'b1);
        smp(8'h00, 8'h00, 8'h00, 1'b1);
        smp(8'h00, 8'h00, 8'h00, 1'b0);
        smp(8'h00, 8'h00, 8'h00, 1'b0);
        smp(8'h0B, 8'h00, 8'h00, 1'b0);
        smp(8'h0B, 8'h00, 8'h00, 1'b1);

        // low-noise cap and threshold end of range
        wr(`DETECT_THRESHOLD_ADDR, 8'hE4);
        wr(`DEBOUNCE_LIMIT_ADDR, 8'h00);
        smp(8'h40, 8'h00, 8'h00, 1'b0);
        @(posedge clock);
        low_noise <= 1'b1;
        smp(8'h40, 8'h00, 8'h00, 1'b1);
        smp(8'h3F, 8'h00, 8'h00, 1'b0);
        @(posedge clock);
        low_noise <= 1'b0;
        wr(`DETECT_THRESHOLD_ADDR, 8'hFF);
        smp(8'h7F, 8'h00, 8'h00, 1'b0);
        smp(8'h80, 8'h00, 8'h00, 1'b1);
        smp(8'h00, 8'h00, 8'h00, 1'b0);

        // latched freefall: freeze, clear on read, fresh count
        wr(`DETECT_CONFIG_ADDR, 8'hB8);
        wr(`DETECT_THRESHOLD_ADDR, 8'h8A);
        wr(`DEBOUNCE_LIMIT_ADDR, 8'h02);
        smp(8'h0B, 8'h00, 8'h00, 1'b0);
        smp(8'h0A, 8'hF6, 8'h00, 1'b0);
        smp(8'h0A, 8'hF6, 8'h00, 1'b1);
        smp(8'h32, 8'h00, 8'h00, 1'b1);
        rd(`DETECT_SOURCE_ADDR, 8'h84);
        rd(`DETECT_SOURCE_ADDR, 8'h00);
        smp(8'h00, 8'h00, 8'h00, 1'b0);
        smp(8'h00, 8'h00, 8'h00, 1'b1);
        rd(`DETECT_SOURCE_ADDR, 8'h80);

        // latched motion with decrement debounce on x only
        wr(`DETECT_CONFIG_ADDR, 8'hC8);
        wr(`DETECT_THRESHOLD_ADDR, 8'h0A);
        smp(8'h0B, 8'h00, 8'h00, 1'b0);
        smp(8'h00, 8'h00, 8'h00, 1'b0);
        smp(8'h0B, 8'h00, 8'h00, 1'b0);
        smp(8'h0B, 8'h00, 8'h00, 1'b1);
        smp(8'h00, 8'h00, 8'h00, 1'b1);
        rd(`DETECT_SOURCE_ADDR, 8'h82);
        smp(8'h0B, 8'h00, 8'h00, 1'b0);
        smp(8'h0B, 8'h00, 8'h00, 1'b1);
        test_done;
    end

endmodule

`undef CHK
`default_nettype wire
